// File: logic/atcsa_arbiter.sv
// transmit arbiter with credit based shaper for av, timing and legacy frames
// assumes byte streams synchronous to clk_sys, one byte time per enabled cycle
// Contract
// RQ1 - three sources: av stream, software-filled timing buffer, legacy stream
// RQ2 - priority: av if allowed, else pending timing packet, else legacy
// RQ3 - legacy path full duplex, no jumbo, vlan allowed, no flow control
// RQ4 - av stream handshake matches legacy except valid between frames
// RQ5 - av source keeps valid and shows next first byte if queued
// RQ6 - av source drops valid right after last transfer when nothing queued
// RQ7 - valid held and credit ok: stay parked on av, take next frame
// RQ8 - credit exceeded at av frame end: leave av regardless of valid
// RQ9 - av frames scheduled only while credit is zero or positive
// RQ10 - negative credit blocks av, legacy scheduled instead
// RQ11 - no av queued: positive credit cleared to zero, negative kept
// RQ12 - av queued but waiting: credit grows by gain rate
// RQ13 - av transmitting: credit falls by drain rate
// RQ14 - credit saturates at fixed bounds not writable by software
// RQ15 - valid dropped between frames loses positive credit, keeps debt
// RQ16 - gain per byte is share/100*8192, in send-slope register
// RQ17 - drain per byte is (100-share)/100*8192, in idle-slope register
// RQ18 - slope reset values give at most 75 percent av share
// RQ19 - software should not program above 75 percent av share
// RQ20 - slopes are per byte so speed change needs no reprogramming
// RQ21 - switch only at frame boundaries; credit updated once per byte time
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module atcsa_arbiter
  import atcsa_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              clk_en,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [AXI_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [AXI_DW-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [7:0]        av_stream_data,
  input  wire logic              av_stream_valid,
  input  wire logic              av_stream_last,
  output logic                   av_stream_ready,
  input  wire logic [7:0]        leg_stream_data,
  input  wire logic              leg_stream_valid,
  input  wire logic              leg_stream_last,
  output logic                   leg_stream_ready,
  output logic [7:0]             tx_data,
  output logic                   tx_valid,
  output logic                   tx_last,
  output logic                   tx_error,
  input  wire logic              tx_ready
);

  // register bus state
  logic                       aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [AXI_AW-1:0]          aw_addr_q, aw_addr_d;
  logic [AXI_DW-1:0]          w_data_q, w_data_d;
  logic [3:0]                 w_strb_q, w_strb_d;
  logic                       bvalid_q, bvalid_d, arready_q, arready_d;
  logic                       rvalid_q, rvalid_d;
  logic [1:0]                 bresp_q, bresp_d, rresp_q, rresp_d;
  logic [AXI_DW-1:0]          rdata_q, rdata_d;
  logic [SLOPE_W-1:0]         gain_q, gain_d, drain_q, drain_d;
  logic                       wr_fire;
  // timing packet buffer
  logic [7:0]                 ptp_mem [PTP_DEPTH];
  logic [PTP_AW:0]            ptp_wr_q, ptp_wr_d;
  logic [PTP_AW-1:0]          ptp_rd_q, ptp_rd_d;
  logic                       ptp_pend_q, ptp_pend_d, ptp_push;
  // scheduler and output stage
  atcsa_src_e                 state_q, state_d;
  logic                       in_frame_q, in_frame_d, rdy_q, rdy_d;
  logic                       av_rdy_q, av_rdy_d, leg_rdy_q, leg_rdy_d;
  logic [7:0]                 txd_q, txd_d;
  logic                       txv_q, txv_d, txl_q, txl_d, txe_q, txe_d;
  logic [LEN_W-1:0]           leg_cnt_q, leg_cnt_d;
  logic                       sel_valid, sel_last, load;
  logic [7:0]                 sel_data;
  logic signed [CREDIT_W-1:0] credit_q, credit_d;
  logic signed [CREDIT_W:0]   cr_wide;
  logic                       credit_ok;

  assign credit_ok = !credit_q[CREDIT_W-1];
  assign wr_fire   = aw_hold_q && w_hold_q && !bvalid_q;
  assign ptp_push  = wr_fire && aw_addr_q == ADDR_PTP_DATA && !ptp_pend_q
                     && !ptp_wr_q[PTP_AW];

  // axi4-lite slave, write address and data taken in either order
  always_comb begin
    aw_hold_d = aw_hold_q;
    aw_addr_d = aw_addr_q;
    w_hold_d  = w_hold_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    gain_d    = gain_q;
    drain_d   = drain_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_OKAY;
      case (aw_addr_q)
        ADDR_GAIN: begin // RQ16
          if (w_strb_q[0]) gain_d[7:0] = w_data_q[7:0];
          if (w_strb_q[1]) gain_d[15:8] = w_data_q[15:8];
        end
        ADDR_DRAIN: begin // RQ17
          if (w_strb_q[0]) drain_d[7:0] = w_data_q[7:0];
          if (w_strb_q[1]) drain_d[15:8] = w_data_q[15:8];
        end
        ADDR_CREDIT, ADDR_STATUS, ADDR_PTP_DATA, ADDR_PTP_CTRL, ADDR_LEG_CFG: begin
          bresp_d = RESP_OKAY;
        end
        default: bresp_d = RESP_SLVERR;
      endcase
    end
    if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
    if (rvalid_q && s_axi_rready) rvalid_d = 1'b0;
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      rdata_d  = '0;
      case (s_axi_araddr)
        ADDR_GAIN:   rdata_d[SLOPE_W-1:0] = gain_q;
        ADDR_DRAIN:  rdata_d[SLOPE_W-1:0] = drain_q;
        ADDR_CREDIT: rdata_d = AXI_DW'(credit_q);
        ADDR_STATUS: begin
          rdata_d[ST_STATE_LSB+:2] = state_q;
          rdata_d[ST_FRAME_BIT]    = in_frame_q;
          rdata_d[ST_PTP_BIT]      = ptp_pend_q;
          rdata_d[ST_AVOK_BIT]     = credit_ok;
        end
        ADDR_PTP_CTRL: rdata_d[PTP_AW:0] = ptp_wr_q;
        ADDR_LEG_CFG:  rdata_d[3:0] = LEG_CFG_VALUE; // RQ3
        ADDR_PTP_DATA: rdata_d = '0;
        default:       rresp_d = RESP_SLVERR;
      endcase
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= '0;
      w_hold_q  <= 1'b0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      gain_q    <= GAIN_RST; // RQ18
      drain_q   <= DRAIN_RST; // RQ18
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
      arready_q <= 1'b0;
    end else if (clk_en) begin
      aw_hold_q <= aw_hold_d;
      aw_addr_q <= aw_addr_d;
      w_hold_q  <= w_hold_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      gain_q    <= gain_d;
      drain_q   <= drain_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      arready_q <= arready_d;
    end
  end

  assign s_axi_awready = clk_en && !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = clk_en && !w_hold_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q && clk_en;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q && clk_en;
  assign s_axi_rvalid  = rvalid_q && clk_en;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // source mux by current grant
  always_comb begin
    sel_valid = 1'b0;
    sel_last  = 1'b0;
    sel_data  = '0;
    case (state_q)
      SRC_AV: begin
        sel_valid = av_stream_valid;
        sel_last  = av_stream_last;
        sel_data  = av_stream_data;
      end
      SRC_PTP: begin
        sel_valid = ptp_pend_q;
        sel_last  = {1'b0, ptp_rd_q} == ptp_wr_q - 1'b1;
        sel_data  = ptp_mem[ptp_rd_q];
      end
      SRC_LEG: begin
        sel_valid = leg_stream_valid;
        sel_last  = leg_stream_last;
        sel_data  = leg_stream_data;
      end
      default: sel_valid = 1'b0;
    endcase
  end
  assign load = rdy_q && sel_valid; // RQ1 RQ4

  // scheduler, output stage and timing buffer
  always_comb begin
    state_d    = state_q;
    in_frame_d = load ? !sel_last : in_frame_q;
    txd_d      = txd_q;
    txl_d      = txl_q;
    txe_d      = txe_q;
    txv_d      = txv_q && !tx_ready;
    leg_cnt_d  = leg_cnt_q;
    ptp_wr_d   = ptp_wr_q;
    ptp_rd_d   = ptp_rd_q;
    ptp_pend_d = ptp_pend_q;
    case (state_q)
      SRC_IDLE: begin
        if (av_stream_valid && credit_ok) state_d = SRC_AV; // RQ2 RQ9
        else if (ptp_pend_q) state_d = SRC_PTP; // RQ2
        else if (leg_stream_valid) state_d = SRC_LEG; // RQ2 RQ10
      end
      SRC_AV: begin
        if (load && sel_last && !credit_ok) state_d = SRC_IDLE; // RQ8
        else if (!in_frame_q && !load && (!av_stream_valid || !credit_ok))
          state_d = SRC_IDLE; // RQ6 RQ21
      end
      SRC_PTP, SRC_LEG: begin
        if (load && sel_last) state_d = SRC_IDLE; // RQ21
      end
      default: state_d = SRC_IDLE;
    endcase
    if (load) begin
      txd_d = sel_data;
      txl_d = sel_last;
      txv_d = 1'b1;
      txe_d = state_q == SRC_LEG && leg_cnt_q >= LEG_MAX_BYTES; // RQ3
      if (state_q == SRC_LEG) leg_cnt_d = sel_last ? '0 : leg_cnt_q + 1'b1;
      if (state_q == SRC_PTP) begin
        ptp_rd_d = ptp_rd_q + 1'b1;
        if (sel_last) begin
          ptp_pend_d = 1'b0;
          ptp_wr_d   = '0;
          ptp_rd_d   = '0;
        end
      end
    end
    if (ptp_push) ptp_wr_d = ptp_wr_q + 1'b1;
    if (wr_fire && aw_addr_q == ADDR_PTP_CTRL && w_data_q[PTP_SEND_BIT]
        && ptp_wr_q != '0 && !ptp_pend_q)
      ptp_pend_d = 1'b1;
    rdy_d     = state_d != SRC_IDLE && !txv_d && !(state_d == SRC_PTP && !ptp_pend_d);
    av_rdy_d  = rdy_d && state_d == SRC_AV; // RQ7
    leg_rdy_d = rdy_d && state_d == SRC_LEG;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q    <= SRC_IDLE;
      in_frame_q <= 1'b0;
      rdy_q      <= 1'b0;
      av_rdy_q   <= 1'b0;
      leg_rdy_q  <= 1'b0;
      txd_q      <= '0;
      txv_q      <= 1'b0;
      txl_q      <= 1'b0;
      txe_q      <= 1'b0;
      leg_cnt_q  <= '0;
      ptp_wr_q   <= '0;
      ptp_rd_q   <= '0;
      ptp_pend_q <= 1'b0;
    end else if (clk_en) begin
      state_q    <= state_d;
      in_frame_q <= in_frame_d;
      rdy_q      <= rdy_d;
      av_rdy_q   <= av_rdy_d;
      leg_rdy_q  <= leg_rdy_d;
      txd_q      <= txd_d;
      txv_q      <= txv_d;
      txl_q      <= txl_d;
      txe_q      <= txe_d;
      leg_cnt_q  <= leg_cnt_d;
      ptp_wr_q   <= ptp_wr_d;
      ptp_rd_q   <= ptp_rd_d;
      ptp_pend_q <= ptp_pend_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clk_en && ptp_push) ptp_mem[ptp_wr_q[PTP_AW-1:0]] <= w_data_q[7:0];
  end

  assign av_stream_ready  = av_rdy_q;
  assign leg_stream_ready = leg_rdy_q;
  assign tx_data          = txd_q;
  assign tx_valid         = txv_q;
  assign tx_last          = txl_q;
  assign tx_error         = txe_q;

  // credit shaper, one step per byte time
  always_comb begin
    if (state_q == SRC_AV)
      cr_wide = (CREDIT_W+1)'(credit_q) - $signed({1'b0, drain_q}); // RQ13 RQ20
    else if (av_stream_valid)
      cr_wide = (CREDIT_W+1)'(credit_q) + $signed({1'b0, gain_q}); // RQ12 RQ20
    else if (credit_ok)
      cr_wide = '0; // RQ11 RQ15
    else
      cr_wide = (CREDIT_W+1)'(credit_q); // RQ15
    if (cr_wide > (CREDIT_W+1)'(CREDIT_UPPER)) credit_d = CREDIT_UPPER; // RQ14
    else if (cr_wide < (CREDIT_W+1)'(CREDIT_LOWER)) credit_d = CREDIT_LOWER; // RQ14
    else credit_d = cr_wide[CREDIT_W-1:0];
  end

  always_ff @(posedge clk_sys) begin
    if (reset) credit_q <= '0;
    else if (clk_en) credit_q <= credit_d; // RQ21
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  AST_AV_BLOCKED_NEG: assert property (clk_en && state_q == SRC_IDLE && !credit_ok // RQ10
    |=> state_q != SRC_AV) else $error("av granted with negative credit");
  AST_AV_FIRST: assert property (clk_en && state_q == SRC_IDLE && av_stream_valid // RQ2
    && credit_ok |=> state_q == SRC_AV) else $error("av not granted first");
  AST_PTP_SECOND: assert property (clk_en && state_q == SRC_IDLE && ptp_pend_q // RQ2
    && !(av_stream_valid && credit_ok) |=> state_q == SRC_PTP)
    else $error("timing packet not granted");
  AST_CLEAR_POS: assert property (clk_en && state_q != SRC_AV && !av_stream_valid // RQ11
    && credit_q > 0 |=> credit_q == 0) else $error("positive credit kept");
  AST_KEEP_NEG: assert property (clk_en && state_q != SRC_AV && !av_stream_valid // RQ15
    && !credit_ok |=> credit_q == $past(credit_q)) else $error("debt changed");
  AST_BOUNDS: assert property (credit_q <= CREDIT_UPPER && credit_q >= CREDIT_LOWER) // RQ14
    else $error("credit out of bounds");
  AST_GAIN: assert property (clk_en && state_q != SRC_AV && av_stream_valid // RQ12
    && credit_q < CREDIT_UPPER - 24'sh010000
    |=> credit_q == $past(credit_q) + $signed({8'h00, $past(gain_q)}))
    else $error("credit gain wrong");
  AST_DRAIN: assert property (clk_en && state_q == SRC_AV // RQ13
    && credit_q > CREDIT_LOWER + 24'sh010000
    |=> credit_q == $past(credit_q) - $signed({8'h00, $past(drain_q)}))
    else $error("credit drain wrong");
  AST_NO_CUT: assert property (in_frame_q && state_q != SRC_IDLE && !(load && sel_last) // RQ21
    |=> state_q == $past(state_q)) else $error("frame interrupted");
  AST_AV_END_NEG: assert property (clk_en && state_q == SRC_AV && load && sel_last // RQ8
    && !credit_ok |=> state_q == SRC_IDLE) else $error("stayed on av in debt");

  COV_AV_PARKED: cover property (state_q == SRC_AV && load && sel_last && credit_ok
    ##1 state_q == SRC_AV);
  COV_PTP_SENT: cover property (state_q == SRC_PTP && load && sel_last);
  COV_LEG_IN_DEBT: cover property (state_q == SRC_LEG && !credit_ok);

endmodule // atcsa_arbiter

// File: shared/atcsa_pkg.sv
// package for the transmit credit shaper arbiter
// assumes a byte-wide transmit stream and an AXI4-Lite register port
package atcsa_pkg;
  localparam int AXI_AW   = 8;
  localparam int AXI_DW   = 32;
  localparam int SLOPE_W  = 16;
  localparam int CREDIT_W = 24;
  localparam int PTP_AW   = 6;
  localparam int PTP_DEPTH = 1 << PTP_AW;
  localparam int LEN_W    = 12;

  // register byte addresses
  localparam logic [AXI_AW-1:0] ADDR_GAIN     = 8'h00;
  localparam logic [AXI_AW-1:0] ADDR_DRAIN    = 8'h04;
  localparam logic [AXI_AW-1:0] ADDR_CREDIT   = 8'h08;
  localparam logic [AXI_AW-1:0] ADDR_STATUS   = 8'h0C;
  localparam logic [AXI_AW-1:0] ADDR_PTP_DATA = 8'h10;
  localparam logic [AXI_AW-1:0] ADDR_PTP_CTRL = 8'h14;
  localparam logic [AXI_AW-1:0] ADDR_LEG_CFG  = 8'h18;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // slopes scaled by 8192 per byte: 75 % share gives 6144 and 2048
  localparam logic [SLOPE_W-1:0] GAIN_RST  = 16'h1800;
  localparam logic [SLOPE_W-1:0] DRAIN_RST = 16'h0800;

  // fixed credit saturation limits
  localparam logic signed [CREDIT_W-1:0] CREDIT_UPPER = 24'sh0FFFFF;
  localparam logic signed [CREDIT_W-1:0] CREDIT_LOWER = 24'shF00000;

  // legacy path: longest non-jumbo frame incl. vlan tag
  localparam logic [LEN_W-1:0] LEG_MAX_BYTES = 12'h5F2;
  // full duplex, no jumbo, vlan allowed, no flow control
  localparam logic [3:0] LEG_CFG_VALUE = 4'h5;

  localparam int ST_STATE_LSB = 0;
  localparam int ST_FRAME_BIT = 2;
  localparam int ST_PTP_BIT   = 3;
  localparam int ST_AVOK_BIT  = 4;
  localparam int PTP_SEND_BIT = 0;

  typedef enum logic [1:0] {SRC_IDLE, SRC_AV, SRC_PTP, SRC_LEG} atcsa_src_e;
endpackage : atcsa_pkg

// File: test/atcsa_stream_src.sv
// byte-stream source standing in for the user logic on one arbiter input
// assumes ready is sampled at the rising clk_sys edge together with clk_en
`timescale 1ns/1ps
module atcsa_stream_src
  import atcsa_pkg::*;
#(
  parameter logic [1:0] TAG = 2'h2
) (
  input  wire logic  clk_sys,
  input  wire logic  reset,
  input  wire logic  clk_en,
  input  wire logic  ready,
  output logic [7:0] data,
  output logic       valid,
  output logic       last
);
  int         lens[$];
  int         pos;
  logic [5:0] cnt;

  task automatic push(input int len);
    lens.push_back(len);
  endtask

  initial begin
    data  = 8'h00;
    valid = 1'b0;
    last  = 1'b0;
    pos   = 0;
    cnt   = 6'h00;
  end

  // payload held until taken; same handshake on both inputs
  always @(posedge clk_sys) begin
    if (valid && ready && clk_en && !reset) begin
      cnt = cnt + 6'h01;
      pos = pos + 1;
      if (last) begin
        void'(lens.pop_front());
        pos = 0;
      end
    end
    if (lens.size() > 0 && !reset) begin
      valid <= 1'b1;
      data  <= {TAG, cnt};
      last  <= (pos == lens[0] - 1);
    end else begin
      valid <= 1'b0;
      data  <= ~data;
      last  <= ~last;
    end
  end
endmodule // atcsa_stream_src

// File: test/tb_avb_tx_credit_shaper_arbiter.sv
// self-checking bench for the credit shaper arbiter
// assumes atcsa_pkg and the stream source model are compiled first
`timescale 1ns/1ps
module tb_avb_tx_credit_shaper_arbiter;
  import atcsa_pkg::*;
  localparam logic [1:0] T_LEG = 2'h1;
  localparam logic [1:0] T_AV  = 2'h2;
  localparam logic [1:0] T_PTP = 2'h3;
  logic clk_sys, reset, clk_en, tx_ready, tx_valid, tx_last, tx_error;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [AXI_DW-1:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, r, cur;
  logic [7:0]        av_stream_data, leg_stream_data, tx_data;
  logic av_stream_valid, av_stream_last, av_stream_ready;
  logic leg_stream_valid, leg_stream_last, leg_stream_ready, in_frame;
  logic [8:0]        exq[4][$];
  logic [5:0]        bcnt[4];
  logic [1:0]        order[$];
  int err_count, comparisons, seed;

  atcsa_arbiter u_atcsa_arbiter (.clk_sys, .reset, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .av_stream_data, .av_stream_valid,
    .av_stream_last, .av_stream_ready, .leg_stream_data, .leg_stream_valid, .leg_stream_last,
    .leg_stream_ready, .tx_data, .tx_valid, .tx_last, .tx_error, .tx_ready);
  atcsa_stream_src #(.TAG(T_AV)) u_av_src (.clk_sys, .reset, .clk_en, .ready(av_stream_ready),
    .data(av_stream_data), .valid(av_stream_valid), .last(av_stream_last));
  atcsa_stream_src #(.TAG(T_LEG)) u_leg_src (.clk_sys, .reset, .clk_en,
    .ready(leg_stream_ready), .data(leg_stream_data), .valid(leg_stream_valid),
    .last(leg_stream_last));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic stop_test();
    $display("mismatches %0d of %0d comparisons", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  task automatic hang(input string nm);
    $display("[ERR] %s expected answer seen none", nm);
    err_count++;
    stop_test();
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    logic ah, wh, bh;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(negedge clk_sys);
      ah = s_axi_awvalid & s_axi_awready;
      wh = s_axi_wvalid & s_axi_wready;
      bh = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk_sys);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (bh) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 200) hang("bvalid");
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int n;
    logic ah, rh;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(negedge clk_sys);
      ah = s_axi_arvalid & s_axi_arready;
      rh = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_sys);
      if (ah) s_axi_arvalid <= 1'b0;
      if (rh) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 200) hang("rvalid");
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    axi_rd(a);
    chk(nm, e, d);
  endtask

  // model side of a frame: expected bytes per source
  task automatic push_frame(input logic [1:0] t, input int len);
    for (int i = 0; i < len; i++) begin
      exq[t].push_back({i == len - 1, t, bcnt[t]});
      if (t == T_PTP) axi_wr(ADDR_PTP_DATA, {24'h0, t, bcnt[t]});
      bcnt[t] = bcnt[t] + 6'h01;
    end
    if (t == T_AV) u_av_src.push(len);
    if (t == T_LEG) u_leg_src.push(len);
  endtask

  task automatic chk_order(input int n, input logic [15:0] seq);
    int k;
    for (k = 0; k < 6000 && order.size() < n; k++) @(posedge clk_sys);
    if (k == 6000) hang("frame order");
    for (int i = 0; i < n; i++) chk("frame source", seq[2*i+:2], order.pop_front());
  endtask

  always @(posedge clk_sys) begin
    clk_en <= ($random(seed) & 7) != 0;
    tx_ready <= ($random(seed) & 3) != 0;
    if (!reset && clk_en && tx_valid && tx_ready) begin
      if (in_frame) chk("frame unbroken", cur, tx_data[7:6]);
      if (exq[tx_data[7:6]].size() == 0) chk("tx byte", 0, 32'hFFFF);
      else chk("tx byte", exq[tx_data[7:6]].pop_front(), {tx_last, tx_data});
      chk("tx_error", 0, tx_error);
      in_frame = !tx_last;
      cur = tx_data[7:6];
      if (tx_last) order.push_back(cur);
    end
  end

  initial begin
    seed = 3;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    {clk_en, tx_ready, reset, in_frame, cur} = 6'h38;
    err_count = 0;
    comparisons = 0;
    for (int i = 0; i < 4; i++) bcnt[i] = 6'h00;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    rd_chk("gain reset", ADDR_GAIN, 32'h0000_1800);
    rd_chk("drain reset", ADDR_DRAIN, 32'h0000_0800);
    rd_chk("credit reset", ADDR_CREDIT, 32'h0);
    rd_chk("legacy cfg", ADDR_LEG_CFG, 32'h0000_0005);
    rd_chk("unmapped data", 8'h1C, 32'h0);
    chk("unmapped resp", RESP_SLVERR, r);
    // av and legacy together, timing packet loaded during the av frame
    push_frame(T_AV, 24);
    push_frame(T_LEG, 4);
    push_frame(T_PTP, 3);
    rd_chk("ptp count", ADDR_PTP_CTRL, 32'h3);
    axi_wr(ADDR_PTP_CTRL, 32'h1);
    chk_order(3, 16'b01_11_10);
    rd_chk("status idle in debt", ADDR_STATUS, 32'h0);
    axi_rd(ADDR_CREDIT);
    chk("credit negative", 1, d[31]);
    chk("credit drain steps", 0, d[10:0]);
    rd_chk("negative kept", ADDR_CREDIT, d);
    // debt blocks av; two queued av frames park the arbiter
    push_frame(T_AV, 3);
    push_frame(T_AV, 3);
    push_frame(T_LEG, 30);
    push_frame(T_LEG, 4);
    chk_order(4, 16'b01_10_10_01);
    rd_chk("positive dropped", ADDR_CREDIT, 32'h0);
    // steep drain overruns the budget in one frame
    axi_wr(ADDR_GAIN, 32'h0);
    axi_wr(ADDR_DRAIN, 32'h4000);
    rd_chk("drain written", ADDR_DRAIN, 32'h4000);
    push_frame(T_AV, 40);
    push_frame(T_AV, 2);
    push_frame(T_LEG, 2);
    chk_order(2, 16'b01_10);
    rd_chk("lower bound", ADDR_CREDIT, 32'hFFF0_0000);
    axi_wr(ADDR_CREDIT, 32'h0);
    chk("read-only write resp", RESP_OKAY, r);
    rd_chk("bound fixed", ADDR_CREDIT, 32'hFFF0_0000);
    axi_wr(ADDR_GAIN, 32'h1800);
    rd_chk("gain written", ADDR_GAIN, 32'h1800);
    chk_order(1, 16'b10);
    stop_test();
  end
endmodule // tb_avb_tx_credit_shaper_arbiter
